// File: core/rxw_core.sv
// Operation
// RULE_01: Restart skips next op when expiry flag is set, then clears flag.
// RULE_02: Swap acc with RAM at data pointer; file pointer XOR immediate.
// RULE_03: Swap-decrement also swaps, XORs and lowers digit pointer mod 16.
// RULE_04: Swap-decrement skips next op when decremented digit pointer is 15.
// RULE_05: Swap-decrement is recognised by code 2Fj, immediate in low nibble.
// RULE_06: Swap-increment also raises digit pointer mod 16, skips on 0.
// RULE_07: Swap-increment is recognised by code 2Ej, immediate in low nibble.
// RULE_08: Restart directly after disable stops the watchdog function.
`timescale 1ns/100ps
module rxw_core (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Instruction issue
  input  wire logic       op_valid,
  input  wire logic [9:0] op_code,
  // Watchdog expiry event from the counter
  input  wire logic       wdog_expire,
  // Architectural state
  output logic      [3:0] acc_r,
  output logic      [3:0] file_ptr_r,
  output logic      [3:0] digit_ptr_r,
  output logic            watchdog_expiry_flag_r,
  output logic            watchdog_run_r,
  output logic            skip_r,
  output logic            busy_r
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SWAP = 2'b10
  } rxw_state_t;

  rxw_state_t st_r;
  rxw_state_t st_nxt;
  logic [5:0] op_lat_r;
  logic [3:0] imm_r;
  logic       prev_dis_r;
  logic [3:0] ram_rdata;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [5:0] opc  = op_code[9:rxw_pkg::OPC_LSB];
  wire [3:0] imm  = op_code[rxw_pkg::IMM_MSB:0];
  wire take       = op_valid && (st_r == ST_IDLE);
  wire is_rst     = take && (op_code == rxw_pkg::WATCHDOG_RESTART_CODE);
  wire is_dis     = take && (op_code == rxw_pkg::WATCHDOG_DISABLE_CODE);
  wire is_swap    = take && (opc == rxw_pkg::SWAP_OPC);
  wire is_dec     = take && (opc == rxw_pkg::SWAP_DEC_OPC); // [RULE_05]
  wire is_inc     = take && (opc == rxw_pkg::SWAP_INC_OPC); // [RULE_07]
  wire any_swap   = is_swap || is_dec || is_inc;
  wire [7:0] addr = {file_ptr_r, digit_ptr_r};

  // Digit pointer moves only in the finishing cycle, so addr holds
  wire [3:0] dig_dec = digit_ptr_r - 4'h1; // [RULE_03]
  wire [3:0] dig_inc = digit_ptr_r + 4'h1; // [RULE_06]
  wire fin          = (st_r == ST_SWAP);
  wire fin_dec      = fin && (op_lat_r == rxw_pkg::SWAP_DEC_OPC);
  wire fin_inc      = fin && (op_lat_r == rxw_pkg::SWAP_INC_OPC);
  wire [3:0] dig_nxt = fin_dec ? dig_dec : (fin_inc ? dig_inc : digit_ptr_r);
  wire skip_dec     = fin_dec && (dig_dec == rxw_pkg::DEC_WRAP); // [RULE_04]
  wire skip_inc     = fin_inc && (dig_inc == rxw_pkg::INC_WRAP); // [RULE_06]
  wire skip_rst     = is_rst && watchdog_expiry_flag_r; // [RULE_01]

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (any_swap) begin
          st_nxt = ST_SWAP;
        end
      end
      // Finishing cycle; the op offered now is dropped, not queued
      ST_SWAP: begin
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // RAM; read takes one cycle, write happens at the finishing cycle
  // ----------------------------------------------------------------
  rxw_ram #(.DW(4), .AW(rxw_pkg::RAM_AW)) u_ram (
    .clk   (clk),
    .we    (fin),
    .addr  (addr),
    .wdata (acc_r),
    .rdata (ram_rdata)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r        <= ST_IDLE;
      op_lat_r    <= 6'h00;
      imm_r       <= 4'h0;
      acc_r       <= rxw_pkg::ACC_RST;
      file_ptr_r  <= rxw_pkg::FILE_RST;
      digit_ptr_r <= rxw_pkg::DIG_RST;
      skip_r      <= 1'b0;
      busy_r      <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      busy_r      <= any_swap;
      skip_r      <= skip_rst || skip_dec || skip_inc;
      digit_ptr_r <= dig_nxt;
      if (any_swap) begin
        op_lat_r <= opc;
        imm_r    <= imm;
      end
      if (fin) begin
        acc_r      <= ram_rdata; // [RULE_02]
        file_ptr_r <= file_ptr_r ^ imm_r; // [RULE_02]
      end
    end
  end

  // Expiry set wins over the restart clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_expiry_flag_r <= 1'b0;
      watchdog_run_r         <= 1'b1;
      prev_dis_r             <= 1'b0;
    end else begin
      if (take) begin
        prev_dis_r <= is_dis;
      end
      if (wdog_expire && watchdog_run_r) begin
        watchdog_expiry_flag_r <= 1'b1;
      end else if (skip_rst) begin
        watchdog_expiry_flag_r <= 1'b0; // [RULE_01]
      end
      if (is_rst && prev_dis_r) begin
        watchdog_run_r <= 1'b0; // [RULE_08]
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_restart_skip: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rstn)
    is_rst |=> (skip_r == $past(watchdog_expiry_flag_r)))
    else $error("restart skip wrong");

  a_restart_clear: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rstn)
    (skip_rst && !wdog_expire) |=> !watchdog_expiry_flag_r)
    else $error("flag not cleared");

  a_expire_set: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rstn)
    (wdog_expire && watchdog_run_r) |=> watchdog_expiry_flag_r)
    else $error("expiry not flagged");

  // Unwritten RAM words read unknown, so identity is compared here
  a_swap_acc: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rstn)
    any_swap |=> ##1 (acc_r === $past(ram_rdata)))
    else $error("acc not loaded from ram");

  a_swap_xor: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rstn)
    any_swap |-> ##2
      (file_ptr_r == ($past(file_ptr_r, 2) ^ $past(imm, 2))))
    else $error("file pointer xor wrong");

  a_plain_hold: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rstn)
    is_swap |-> ##2 (digit_ptr_r == $past(digit_ptr_r, 2)))
    else $error("plain swap moved digit pointer");

  a_busy_refuse: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rstn)
    (busy_r && op_valid) |=> !busy_r)
    else $error("op taken while busy");

  a_dec_step: assert property ( // [RULE_03]
    @(posedge clk) disable iff (!rstn)
    is_dec |-> ##2 (digit_ptr_r == $past(digit_ptr_r, 2) - 4'h1))
    else $error("decrement wrong");

  a_dec_skip: assert property ( // [RULE_04]
    @(posedge clk) disable iff (!rstn)
    is_dec |-> ##2 (skip_r == (digit_ptr_r == 4'hf)))
    else $error("decrement skip wrong");

  a_dec_decode: assert property ( // [RULE_05]
    @(posedge clk) disable iff (!rstn)
    (take && op_code[9:4] == 6'h2f) |=> busy_r)
    else $error("2Fj not decoded");

  a_inc_skip: assert property ( // [RULE_06]
    @(posedge clk) disable iff (!rstn)
    is_inc |-> ##2 ((skip_r == (digit_ptr_r == 4'h0)) &&
      (digit_ptr_r == $past(digit_ptr_r, 2) + 4'h1)))
    else $error("increment wrong");

  a_inc_decode: assert property ( // [RULE_07]
    @(posedge clk) disable iff (!rstn)
    (take && op_code[9:4] == 6'h2e) |=> (st_r == ST_SWAP))
    else $error("2Ej not decoded");

  a_wdog_stop: assert property ( // [RULE_08]
    @(posedge clk) disable iff (!rstn)
    (is_rst && prev_dis_r) |=> !watchdog_run_r)
    else $error("watchdog not stopped");

  a_stop_hold: assert property ( // [RULE_08]
    @(posedge clk) disable iff (!rstn)
    !watchdog_run_r |=> !watchdog_run_r)
    else $error("watchdog restarted");

  a_stop_mask: assert property ( // [RULE_08]
    @(posedge clk) disable iff (!rstn)
    (!watchdog_run_r && !watchdog_expiry_flag_r) |=>
      !watchdog_expiry_flag_r)
    else $error("expiry flagged while stopped");
endmodule // rxw_core

// File: core/rxw_pkg.sv
package rxw_pkg;
  // Instruction codes: restart 10 bits, swap opcodes the upper 6 of 10 bits
  localparam logic [9:0] WATCHDOG_RESTART_CODE = 10'h2a0;
  localparam logic [5:0] SWAP_OPC      = 6'h2d;
  localparam logic [5:0] SWAP_DEC_OPC  = 6'h2f;
  localparam logic [5:0] SWAP_INC_OPC  = 6'h2e;
  // Watchdog disable code, a value of our own choosing
  localparam logic [9:0] WATCHDOG_DISABLE_CODE = 10'h29c;
  // Field positions
  localparam int OPC_LSB = 4;
  localparam int IMM_MSB = 3;
  // Reset values
  localparam logic [3:0] ACC_RST  = 4'h0;
  localparam logic [3:0] FILE_RST = 4'h0;
  localparam logic [3:0] DIG_RST  = 4'h0;
  // Skip values
  localparam logic [3:0] DEC_WRAP = 4'hf;
  localparam logic [3:0] INC_WRAP = 4'h0;
  // Memory
  localparam int RAM_DEPTH = 256;
  localparam int RAM_AW    = 8;
endpackage

// File: core/rxw_ram.sv
`timescale 1ns/100ps
module rxw_ram #(
  parameter int DW = 4,
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // Refuse sizes the array cannot sensibly hold
  if (DW < 1 || AW < 1 || AW > 12) begin : g_size_check
    $error("rxw_ram: unsupported size");
  end

  // Registered read: old word appears the cycle after addr
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // rxw_ram

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  localparam logic [9:0] WD_RST = rxw_pkg::WATCHDOG_RESTART_CODE;
  localparam logic [9:0] WD_DIS = rxw_pkg::WATCHDOG_DISABLE_CODE;
  logic        clk, rstn, op_valid, wdog_expire;
  logic [9:0]  op_code;
  logic [3:0]  acc_r, file_ptr_r, digit_ptr_r;
  logic        wflag, wrun, skip_r, busy_r;
  int          failures, tests_run;
  logic [31:0] s = 32'h3263;
  logic [31:0] r;
  logic [3:0]  a, x, y, mem[256];
  bit          ka, kn[256];

  rxw_core i_dut (.clk(clk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .wdog_expire(wdog_expire), .acc_r(acc_r),
    .file_ptr_r(file_ptr_r), .digit_ptr_r(digit_ptr_r),
    .watchdog_expiry_flag_r(wflag), .watchdog_run_r(wrun),
    .skip_r(skip_r), .busy_r(busy_r));

  function logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function logic exp_skip(input logic [1:0] k, input logic [3:0] d);
    return (k == 2'd1 && d == rxw_pkg::INC_WRAP) ||
      (k == 2'd2 && d == rxw_pkg::DEC_WRAP);
  endfunction

  task chk(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("failures %0d of %0d checks", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Offer one op after the next edge, return while its result stands;
  // a swap also has a stray op offered in its busy cycle
  task op(input logic [9:0] c, input logic [9:0] junk);
    logic sw;
    @(posedge clk);
    #1;
    sw = c[9:4] inside {6'h2d, 6'h2e, 6'h2f};
    op_valid = 1;
    op_code = c;
    @(posedge clk);
    #1;
    op_valid = sw;
    op_code = junk;
    if (sw) begin
      chk(4'(busy_r), 4'h1);
      @(posedge clk);
      #1;
      op_valid = 0;
    end
  endtask

  task swap(input logic [1:0] k, input logic [3:0] j);
    logic [7:0] ad;
    logic [3:0] om;
    logic       kk;
    ad = {x, y};
    kk = kn[ad];
    om = mem[ad];
    op({k == 1 ? 6'h2e : k == 2 ? 6'h2f : 6'h2d, j}, {6'h2e, ~j});
    if (kk) chk(acc_r, om);
    mem[ad] = a;
    kn[ad] = ka;
    a = om;
    ka = kk;
    x ^= j;
    y = k == 1 ? y + 4'h1 : k == 2 ? y - 4'h1 : y;
    chk(file_ptr_r, x);
    chk(digit_ptr_r, y);
    chk(4'(skip_r), 4'(exp_skip(k, y)));
  endtask

  task expire;
    wdog_expire = 1;
    @(posedge clk);
    #1 wdog_expire = 0;
  endtask

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #10us;
    failures++;
    close_out;
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {rstn, op_valid, op_code, wdog_expire, a, x, y, ka} = '0;
    ka = 1;
    repeat (12) @(posedge clk);
    #1 rstn = 1;
    chk(acc_r, 4'h0);
    chk(4'(wrun), 4'h1);
    op(WD_RST, 10'h0);
    chk(4'(skip_r), 4'h0);
    expire;
    chk(4'(wflag), 4'h1);
    op(WD_RST, 10'h0);
    chk({3'h0, skip_r}, 4'h1);
    chk(4'(wflag), 4'h0);
    op(WD_DIS, 10'h0);
    swap(2'd2, 4'h0);
    // Round trip back to word 00 brings its known value back
    swap(2'd1, 4'h0);
    swap(2'd0, 4'h0);
    op(WD_RST, 10'h0);
    chk(4'(wrun), 4'h1);
    op(WD_DIS, 10'h0);
    op(WD_RST, 10'h0);
    chk(4'(wrun), 4'h0);
    // Expiry must be ignored once the watchdog is stopped
    expire;
    chk(4'(wflag), 4'h0);
    repeat (90) begin
      r = xs();
      swap(2'(r % 3), r[7:4]);
    end
    close_out;
  end
endmodule // tb_top
